// ---- design/lane_stream_consts.vh ----
// Purpose: Shared constants for the lane stream user interface
// Assumes: 2-byte code groups per lane
// Notes: Lane kind codes tag each code group on the lane side
`ifndef LANE_STREAM_CONSTS_VH
`define LANE_STREAM_CONSTS_VH

// ----------------------------------------
// Lane code group kinds
// ----------------------------------------
`define KIND_IDLE 3'h0
`define KIND_DATA 3'h1
`define KIND_DATA_PAD 3'h2
`define KIND_START 3'h3
`define KIND_END 3'h4
`define KIND_CC 3'h5

// ----------------------------------------
// Clock compensation timing
// ----------------------------------------
`define LANE_BYTES 2
`define CC_INTERVAL_BYTES 10000
`define CC_SEQ_BYTES 12
`define CC_PERIOD_CYCLES (`CC_INTERVAL_BYTES / `LANE_BYTES)
`define CC_LEN_CYCLES (`CC_SEQ_BYTES / `LANE_BYTES)

// ----------------------------------------
// Defaults
// ----------------------------------------
`define DEFAULT_LANES 4

`endif

// ---- design/lane_stream_user_interface.v ----
// Purpose: User word interface of a multi-lane 8B/10B link, framing or streaming
// Assumes: Lane side and channel-up logic run on CLK; lane 0 is the leftmost lane
// Notes: Two word registers on each path (one on receive when streaming); fixed latency apart from clock compensation and framing receive gaps
`include "lane_stream_consts.vh"
`timescale 1ns/1ps

module lane_stream_user_interface #(
    parameter LANES = `DEFAULT_LANES,
    parameter FRAMING = 1,
    parameter HAS_TX = 1,
    parameter HAS_RX = 1,
    parameter [15:0] CC_PERIOD = `CC_PERIOD_CYCLES,
    parameter [3:0] CC_LEN = `CC_LEN_CYCLES
) (
    input wire CLK,
    input wire SYS_RST,
    input wire CHANNEL_UP,
    input wire [16*LANES-1:0] TX_TDATA,
    input wire TX_TVALID,
    input wire TX_TLAST,
    input wire [2*LANES-1:0] TX_TKEEP,
    output wire TX_TREADY,
    output reg [16*LANES-1:0] RX_TDATA,
    output reg RX_TVALID,
    output reg RX_TLAST,
    output reg [2*LANES-1:0] RX_TKEEP,
    output wire CLOCK_COMP_REQUEST,
    output reg [16*LANES-1:0] LANE_TX_DATA,
    output reg [3*LANES-1:0] LANE_TX_KIND,
    input wire [16*LANES-1:0] LANE_RX_DATA,
    input wire [3*LANES-1:0] LANE_RX_KIND
);

    localparam W = 16 * LANES;
    localparam KW = 3 * LANES;
    localparam BW = 2 * LANES;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Kind of one outgoing lane from its two keep bits
    function [2:0] tx_kind;
        input [1:0] keep2;
        input last;
        begin
            if (!last) begin
                tx_kind = `KIND_DATA;
            end else if (keep2 == 2'h3) begin
                tx_kind = `KIND_DATA;
            end else if (keep2 == 2'h2) begin
                tx_kind = `KIND_DATA_PAD;
            end else begin
                tx_kind = `KIND_IDLE;
            end
        end
    endfunction

    // Keep bits recovered from an incoming lane kind
    function [1:0] rx_keep;
        input [2:0] kind;
        begin
            if (kind == `KIND_DATA) begin
                rx_keep = 2'h3;
            end else if (kind == `KIND_DATA_PAD) begin
                rx_keep = 2'h2;
            end else begin
                rx_keep = 2'h0;
            end
        end
    endfunction

    // ----------------------------------------
    // Clock compensation scheduler
    // ----------------------------------------
    reg [15:0] cc_count;
    reg [3:0] cc_left;
    wire cc_active = (cc_left != 4'h0);

    assign CLOCK_COMP_REQUEST = cc_active;

    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cc_count <= 16'h0000;
            cc_left <= 4'h0;
        end else if (!CHANNEL_UP) begin
            cc_count <= 16'h0000;
            cc_left <= 4'h0;
        end else if (cc_count == CC_PERIOD - 16'h0001) begin
            cc_count <= 16'h0000;
            cc_left <= CC_LEN;
        end else begin
            cc_count <= cc_count + 16'h0001;
            if (cc_active) begin
                cc_left <= cc_left - 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    reg [W-1:0] hold_data;
    reg [BW-1:0] hold_keep;
    reg hold_valid;
    reg hold_last;
    reg in_frame;
    reg end_pending;
    reg [W-1:0] next_lane_data;
    reg [KW-1:0] next_lane_kind;
    integer i;

    // Ready drops for the closing groups so a new frame cannot collide with them
    wire tx_ready = (HAS_TX != 0) && CHANNEL_UP && !cc_active
        && !(hold_valid && hold_last) && !end_pending;
    wire accept = TX_TVALID && tx_ready;
    wire first_beat = accept && (FRAMING != 0) && !in_frame;

    assign TX_TREADY = tx_ready;

    always @* begin
        next_lane_data = {W{1'b0}};
        next_lane_kind = {KW{1'b0}};
        for (i = 0; i < LANES; i = i + 1) begin
            next_lane_kind[KW-1-3*i -: 3] = `KIND_IDLE;
        end
        if (cc_active) begin
            for (i = 0; i < LANES; i = i + 1) begin
                next_lane_kind[KW-1-3*i -: 3] = `KIND_CC;
            end
        end else if (end_pending) begin
            next_lane_kind[2:0] = `KIND_END;
        end else if (first_beat) begin
            next_lane_kind[KW-1 -: 3] = `KIND_START;
        end else if (hold_valid) begin
            for (i = 0; i < LANES; i = i + 1) begin
                next_lane_kind[KW-1-3*i -: 3] =
                    tx_kind(hold_keep[BW-1-2*i -: 2], hold_last);
                if (next_lane_kind[KW-1-3*i -: 3] == `KIND_DATA) begin
                    next_lane_data[W-1-16*i -: 16] = hold_data[W-1-16*i -: 16];
                end else if (next_lane_kind[KW-1-3*i -: 3] == `KIND_DATA_PAD) begin
                    next_lane_data[W-1-16*i -: 8] = hold_data[W-1-16*i -: 8];
                end
            end
        end
    end

    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            LANE_TX_DATA <= {W{1'b0}};
            LANE_TX_KIND <= {KW{1'b0}};
            hold_data <= {W{1'b0}};
            hold_keep <= {BW{1'b0}};
            hold_valid <= 1'b0;
            hold_last <= 1'b0;
            in_frame <= 1'b0;
            end_pending <= 1'b0;
        end else if (!CHANNEL_UP) begin
            LANE_TX_DATA <= {W{1'b0}};
            LANE_TX_KIND <= {KW{1'b0}};
            hold_valid <= 1'b0;
            hold_last <= 1'b0;
            in_frame <= 1'b0;
            end_pending <= 1'b0;
        end else begin
            LANE_TX_DATA <= next_lane_data;
            LANE_TX_KIND <= next_lane_kind;
            // Held word stays frozen during compensation, so nothing is lost
            if (!cc_active) begin
                if (end_pending) begin
                    end_pending <= 1'b0;
                    in_frame <= 1'b0;
                end else if (first_beat) begin
                    in_frame <= 1'b1;
                end else if (hold_valid && hold_last) begin
                    end_pending <= 1'b1;
                end
                hold_valid <= accept;
                if (accept) begin
                    hold_data <= TX_TDATA;
                    hold_keep <= TX_TKEEP;
                    hold_last <= TX_TLAST && (FRAMING != 0);
                end
            end
        end
    end

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    reg [W-1:0] rx_word;
    reg [BW-1:0] rx_keep_now;
    reg [W-1:0] rhold_data;
    reg [BW-1:0] rhold_keep;
    reg rhold_valid;
    wire rx_has = |rx_keep_now;
    wire rx_end = (LANE_RX_KIND[2:0] == `KIND_END);
    wire rx_on = (HAS_RX != 0) && CHANNEL_UP;

    always @* begin
        rx_word = LANE_RX_DATA;
        rx_keep_now = {BW{1'b0}};
        for (i = 0; i < LANES; i = i + 1) begin
            rx_keep_now[BW-1-2*i -: 2] = rx_keep(LANE_RX_KIND[KW-1-3*i -: 3]);
        end
    end

    // No backpressure here: the user must take each valid word at once
    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            RX_TDATA <= {W{1'b0}};
            RX_TVALID <= 1'b0;
            RX_TLAST <= 1'b0;
            RX_TKEEP <= {BW{1'b0}};
            rhold_data <= {W{1'b0}};
            rhold_keep <= {BW{1'b0}};
            rhold_valid <= 1'b0;
        end else if (!rx_on) begin
            RX_TVALID <= 1'b0;
            RX_TLAST <= 1'b0;
            rhold_valid <= 1'b0;
        end else if (FRAMING == 0) begin
            RX_TVALID <= rx_has;
            RX_TLAST <= 1'b0;
            RX_TKEEP <= rx_keep_now;
            if (rx_has) begin
                RX_TDATA <= rx_word;
            end
        end else begin
            // Last word is held until the next group shows whether it ends the frame
            RX_TVALID <= rhold_valid && (rx_has || rx_end);
            RX_TLAST <= rhold_valid && rx_end && !rx_has;
            if (rhold_valid && (rx_has || rx_end)) begin
                RX_TDATA <= rhold_data;
                RX_TKEEP <= rhold_keep;
            end
            if (rx_has) begin
                rhold_data <= rx_word;
                rhold_keep <= rx_keep_now;
                rhold_valid <= 1'b1;
            end else if (rx_end) begin
                rhold_valid <= 1'b0;
            end
        end
    end

endmodule

// ---- dv/lane_stream_chk.sv ----
// Purpose: Port-level assertions for the lane stream user interface
// Assumes: Streaming mode; bench sets compensation period to 40 cycles
// Notes: Delimiter placement checks hold in either mode
`timescale 1ns/1ps
`include "lane_stream_consts.vh"
module lane_stream_chk #(parameter LANES = 2) (
    input wire CLK,
    input wire SYS_RST,
    input wire CHANNEL_UP,
    input wire TX_TVALID,
    input wire TX_TREADY,
    input wire [16*LANES-1:0] RX_TDATA,
    input wire RX_TVALID,
    input wire CLOCK_COMP_REQUEST,
    input wire [3*LANES-1:0] LANE_TX_KIND,
    input wire [16*LANES-1:0] LANE_RX_DATA,
    input wire [3*LANES-1:0] LANE_RX_KIND
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic bad_start;
    logic bad_end;
    always_comb begin
        bad_start = 1'b0;
        bad_end = 1'b0;
        for (int i = 0; i < LANES; i++) begin
            if (i > 0 && LANE_TX_KIND[3*(LANES-1-i)+:3] == `KIND_START) bad_start = 1'b1;
            if (i < LANES-1 && LANE_TX_KIND[3*(LANES-1-i)+:3] == `KIND_END) bad_end = 1'b1;
        end
    end
    sequence cc_burst;
        CLOCK_COMP_REQUEST [*6] ##1 !CLOCK_COMP_REQUEST;
    endsequence
    sequence rx_word;
        CHANNEL_UP && LANE_RX_KIND == {LANES{`KIND_DATA}};
    endsequence
    AST_START_LANE0: assert property (!bad_start) else $error("start outside lane 0");
    AST_END_LAST: assert property (!bad_end) else $error("end outside last lane");
    AST_DOWN_READY: assert property (!CHANNEL_UP |-> !TX_TREADY) else $error("ready while down");
    AST_DOWN_RX: assert property (!CHANNEL_UP |=> !RX_TVALID) else $error("rx valid while down");
    AST_CC_READY: assert property (CLOCK_COMP_REQUEST |-> !TX_TREADY) else $error("ready in cc");
    AST_CC_LEN: assert property ($rose(CLOCK_COMP_REQUEST) |-> cc_burst) else $error("cc length");
    AST_CC_PERIOD: assert property ($rose(CLOCK_COMP_REQUEST) |-> ##40 $rose(CLOCK_COMP_REQUEST))
        else $error("cc period");
    AST_CC_LANES: assert property (CLOCK_COMP_REQUEST |-> ##[0:1] LANE_TX_KIND == {LANES{`KIND_CC}})
        else $error("lanes not in cc");
    AST_TX_TO_LANE: assert property (TX_TVALID && TX_TREADY |-> ##[2:8] LANE_TX_KIND[3*LANES-1-:3] == `KIND_DATA)
        else $error("word not sent");
    AST_RX_OUT: assert property (rx_word |=> RX_TVALID && RX_TDATA == $past(LANE_RX_DATA))
        else $error("rx word wrong");
    AST_RX_IDLE: assert property (CHANNEL_UP && LANE_RX_KIND == {LANES{`KIND_IDLE}} |=> !RX_TVALID)
        else $error("rx valid on idle");
endmodule
bind lane_stream_user_interface lane_stream_chk #(.LANES(LANES)) u_chk (.CLK(CLK),
    .SYS_RST(SYS_RST), .CHANNEL_UP(CHANNEL_UP), .TX_TVALID(TX_TVALID), .TX_TREADY(TX_TREADY),
    .RX_TDATA(RX_TDATA), .RX_TVALID(RX_TVALID), .CLOCK_COMP_REQUEST(CLOCK_COMP_REQUEST),
    .LANE_TX_KIND(LANE_TX_KIND), .LANE_RX_DATA(LANE_RX_DATA), .LANE_RX_KIND(LANE_RX_KIND));

// ---- dv/lane_loop_partner.sv ----
// Purpose: Channel partner returning every lane code group one cycle later
// Assumes: Both ends share CLK
// Notes: Non-data cycles carry changing junk so stale words cannot pass
`timescale 1ns/1ps
`include "lane_stream_consts.vh"
module lane_loop_partner #(parameter LANES = 2) (
    input wire CLK,
    input wire [16*LANES-1:0] TX_DATA,
    input wire [3*LANES-1:0] TX_KIND,
    output logic [16*LANES-1:0] RX_DATA = '0,
    output logic [3*LANES-1:0] RX_KIND = '0
);
    // Gaps and order kept as sent
    always @(posedge CLK) begin
        RX_KIND <= TX_KIND;
        RX_DATA <= (TX_KIND == {LANES{`KIND_DATA}}) ? TX_DATA : ~RX_DATA;
    end
endmodule

// ---- dv/lane_stream_user_interface_test.sv ----
// Purpose: Streaming bench with a loopback channel partner
// Assumes: Two lanes, short compensation period of 40 cycles
// Notes: Framing placement left to the checker
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module lane_stream_user_interface_test;
    logic CLK = 0, SYS_RST = 1, CHANNEL_UP = 0, TX_TVALID = 0;
    logic [31:0] TX_TDATA = '0, RX_TDATA, LANE_TX_DATA, LANE_RX_DATA;
    logic TX_TREADY, RX_TVALID, RX_TLAST, CLOCK_COMP_REQUEST;
    logic [3:0] RX_TKEEP;
    logic [5:0] LANE_TX_KIND, LANE_RX_KIND;
    logic [31:0] sent[$], got[$];
    logic TX_TLAST = 1'b0;
    logic [3:0] TX_TKEEP = 4'hf;
    int num_errors = 0, n_compared = 0, bad_side = 0;
    always #4 CLK = ~CLK;
    lane_stream_user_interface #(.LANES(2), .FRAMING(0), .CC_PERIOD(16'd40), .CC_LEN(4'd6)) DUT (
        .CLK(CLK), .SYS_RST(SYS_RST), .CHANNEL_UP(CHANNEL_UP), .TX_TDATA(TX_TDATA),
        .TX_TVALID(TX_TVALID), .TX_TLAST(TX_TLAST), .TX_TKEEP(TX_TKEEP), .TX_TREADY(TX_TREADY),
        .RX_TDATA(RX_TDATA), .RX_TVALID(RX_TVALID), .RX_TLAST(RX_TLAST), .RX_TKEEP(RX_TKEEP),
        .CLOCK_COMP_REQUEST(CLOCK_COMP_REQUEST), .LANE_TX_DATA(LANE_TX_DATA),
        .LANE_TX_KIND(LANE_TX_KIND), .LANE_RX_DATA(LANE_RX_DATA), .LANE_RX_KIND(LANE_RX_KIND));
    lane_loop_partner #(.LANES(2)) partner (.CLK(CLK), .TX_DATA(LANE_TX_DATA),
        .TX_KIND(LANE_TX_KIND), .RX_DATA(LANE_RX_DATA), .RX_KIND(LANE_RX_KIND));
    // No backpressure, so every valid word is grabbed at once
    always @(posedge CLK) begin
        if (RX_TVALID === 1'b1) begin
            got.push_back(RX_TDATA);
            // Streaming ignores frame sidebands, so they must come back neutral
            if (RX_TLAST !== 1'b0 || RX_TKEEP !== 4'hf) bad_side++;
        end
    end
    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task t_link_down;
        repeat (5) begin
            @(negedge CLK);
            `CHK(TX_TREADY, 1'b0)
            `CHK(RX_TVALID, 1'b0)
        end
        $display("t_link_down done");
    endtask
    // Holds the word until a falling edge sees ready high, for at most 20 falling edges
    task send(input logic [31:0] w);
        TX_TDATA <= w;
        TX_TVALID <= 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(negedge CLK);
            if (TX_TREADY === 1'b1) break;
        end
        @(posedge CLK);
        sent.push_back(w);
    endtask
    task t_stream;
        for (int i = 0; i < 60; i++) begin
            TX_TLAST <= (i % 5 == 0);
            TX_TKEEP <= (i % 3 == 0) ? 4'h8 : 4'hf;
            send(32'ha5000000 + i);
            if (i % 7 == 3) begin
                TX_TVALID <= 1'b0;
                @(posedge CLK);
            end
        end
        TX_TVALID <= 1'b0;
        repeat (20) @(posedge CLK);
        `CHK(got.size(), sent.size())
        `CHK(bad_side, 0)
        foreach (sent[i]) if (i < got.size()) `CHK(got[i], sent[i])
        $display("t_stream done");
    endtask
    task t_cc;
        int n;
        n = 0;
        for (int k = 0; k < 60 && CLOCK_COMP_REQUEST !== 1'b1; k++) @(negedge CLK);
        while (CLOCK_COMP_REQUEST === 1'b1 && n < 20) begin
            `CHK(TX_TREADY, 1'b0)
            n++;
            @(negedge CLK);
        end
        `CHK(n, 6)
        `CHK(TX_TREADY, 1'b1)
        $display("t_cc done");
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_link_down();
        @(posedge CLK);
        CHANNEL_UP <= 1'b1;
        @(posedge CLK);
        t_stream();
        t_cc();
        close_out();
    end
    initial begin
        #24000;
        num_errors++;
        close_out();
    end
endmodule
